// [hw/gst_pkg.sv]
`default_nettype none

// ----------------------------------------------------------------
// Shared constants of the gated sixteen-bit timer
// ----------------------------------------------------------------
package gst_pkg;

	// Clock rate and the instruction clock, which runs at a quarter of it
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned INSTR_DIV     = 4;
	localparam logic [1:0]  INSTR_LAST    = 2'(INSTR_DIV - 1);

	// Register bus shape and register offsets
	localparam int unsigned ADDR_W        = 3;
	localparam int unsigned DATA_W        = 8;
	localparam logic [2:0]  OFS_COUNT_LOW = 3'h0;
	localparam logic [2:0]  OFS_COUNT_HIGH = 3'h1;
	localparam logic [2:0]  OFS_TIMER_CTL = 3'h2;
	localparam logic [2:0]  OFS_GATE_CTL  = 3'h3;
	localparam logic [2:0]  OFS_AUX       = 3'h4;

	// timer_control_reg fields
	localparam int unsigned TCR_ON_BIT    = 0;
	localparam int unsigned TCR_SYNC_BIT  = 2;
	localparam int unsigned TCR_OSC_BIT   = 3;
	localparam int unsigned TCR_PS_LSB    = 4;
	localparam int unsigned TCR_CS_LSB    = 6;
	localparam logic [7:0]  TCR_RW_MASK   = 8'hfd;
	localparam logic [7:0]  TCR_RESET     = 8'h00;

	// gate_control_reg fields
	localparam int unsigned GCR_GSS_LSB   = 0;
	localparam int unsigned GCR_TM_BIT    = 5;
	localparam int unsigned GCR_POL_BIT   = 6;
	localparam int unsigned GCR_GE_BIT    = 7;
	localparam logic [7:0]  GCR_RW_MASK   = 8'he3;
	localparam logic [7:0]  GCR_RESET     = 8'h00;

	// Auxiliary register: overflow flag and comparator sync select
	localparam int unsigned AUX_OVF_BIT   = 0;
	localparam int unsigned AUX_CSYNC_BIT = 1;
	localparam logic        AUX_CSYNC_RESET = 1'b0;

	// Counter and eight-bit timer values
	localparam logic [15:0] COUNT_RESET   = 16'h0000;
	localparam logic [15:0] COUNT_MAX     = 16'hffff;
	localparam logic [7:0]  T0_MAX        = 8'hff;
	localparam logic [7:0]  T0_ZERO       = 8'h00;

	typedef enum logic [1:0] {
		GST_CS_INSTR = 2'b00,
		GST_CS_SYS   = 2'b01,
		GST_CS_PIN   = 2'b10,
		GST_CS_CAP   = 2'b11
	} gst_clk_src_t;

	typedef enum logic [1:0] {
		GST_GS_PIN   = 2'b00,
		GST_GS_T0OVF = 2'b01,
		GST_GS_COMP  = 2'b10,
		GST_GS_RSVD  = 2'b11
	} gst_gate_src_t;

	// True for the sources that arrive from outside the clock domain
	function automatic logic gst_is_ext(input gst_clk_src_t cs);
		return cs[1];
	endfunction : gst_is_ext

endpackage : gst_pkg

`default_nettype wire

// [hw/gst_link_if.sv]
`default_nettype none

// ----------------------------------------------------------------
// Signals between the timer core, its prescaler and its gate
// ----------------------------------------------------------------
interface gst_link_if;
	logic       raw_tick;     // Selected source edge, before division
	logic       cnt_clear;    // Clears the prescale counter
	logic [1:0] ps_sel;       // Prescale field
	logic       pre_tick;     // Divided tick
	logic       timer_on;     // Timer enabled
	logic       toggle_mode;  // Gate toggle mode
	logic       gate_pol;     // Gate polarity
	logic [1:0] gate_sel;     // Gate source field
	logic       comp_sync;    // Comparator sampled on timer ticks
	logic       gate_pin;     // Gate pin level
	logic [7:0] t0_count;     // Eight-bit timer value
	logic       comp_out;     // Comparator output
	logic       gate_open;    // Gate lets the counter advance

	modport core (output raw_tick, cnt_clear, ps_sel, timer_on, toggle_mode, gate_pol, gate_sel,
		comp_sync, gate_pin, t0_count, comp_out, input pre_tick, gate_open);
	modport pre  (input raw_tick, cnt_clear, ps_sel, output pre_tick);
	modport gate (input pre_tick, timer_on, toggle_mode, gate_pol, gate_sel, comp_sync, gate_pin,
		t0_count, comp_out, output gate_open);
endinterface : gst_link_if

`default_nettype wire

// [hw/gst_prescaler.sv]
`default_nettype none

// ----------------------------------------------------------------
// Divide-by-1/2/4/8 prescaler
// ----------------------------------------------------------------
module gst_prescaler (
	input  wire logic clk,   // System clock
	input  wire logic nrst,  // Synchronous reset, active low
	input  wire logic ce,    // Clock enable
	gst_link_if.pre   lnk    // Tick path
);
	import gst_pkg::*;

	logic [2:0] div_q;
	logic [2:0] last;

	// Last count before wrap: 0, 1, 3 or 7
	assign last = 3'((4'h1 << lnk.ps_sel) - 4'h1);
	assign lnk.pre_tick = lnk.raw_tick && !lnk.cnt_clear && (div_q >= last);

	// Hidden counter; a count byte write clears it, a lowered divide wraps at once instead of running on to 7
	always_ff @(posedge clk) begin
		if (!nrst) begin
			div_q <= 3'h0;
		end else if (ce) begin
			if (lnk.cnt_clear) begin
				div_q <= 3'h0;
			end else if (lnk.raw_tick) begin
				div_q <= (div_q >= last) ? 3'h0 : 3'(div_q + 3'h1);
			end
		end
	end

	a_presc_clear: assert property (@(posedge clk) disable iff (!nrst) ce && lnk.cnt_clear |=> div_q == 3'h0)
		else $error("prescaler not cleared by count write");
	a_div_by_one: assert property (@(posedge clk) disable iff (!nrst)
		lnk.ps_sel == 2'b00 && lnk.raw_tick && !lnk.cnt_clear |-> lnk.pre_tick)
		else $error("divide by one dropped a tick");

endmodule : gst_prescaler

`default_nettype wire

// [hw/gst_gate.sv]
`default_nettype none

// ----------------------------------------------------------------
// Gate source select, polarity and toggle flip-flop
// ----------------------------------------------------------------
module gst_gate (
	input  wire logic clk,   // System clock
	input  wire logic nrst,  // Synchronous reset, active low
	input  wire logic ce,    // Clock enable
	gst_link_if.gate  lnk    // Gate controls and result
);
	import gst_pkg::*;

	logic [7:0] t0_prev_q;
	logic       t0_pulse_q;
	logic       comp_s_q;
	logic       src;
	logic       active;
	logic       active_prev_q;
	logic       tff_q;

	// Roll-over of the eight-bit timer becomes a one-cycle high pulse
	always_ff @(posedge clk) begin
		if (!nrst) begin
			t0_prev_q  <= T0_ZERO;
			t0_pulse_q <= 1'b0;
		end else if (ce) begin
			t0_prev_q  <= lnk.t0_count;
			t0_pulse_q <= (t0_prev_q == T0_MAX) && (lnk.t0_count == T0_ZERO);
		end
	end

	// Comparator copy taken only on timer ticks
	always_ff @(posedge clk) begin
		if (!nrst) begin
			comp_s_q <= 1'b0;
		end else if (ce && lnk.pre_tick) begin
			comp_s_q <= lnk.comp_out;
		end
	end

	// Source select; the reserved code reads as a steady low
	always_comb begin
		case (gst_gate_src_t'(lnk.gate_sel))
			GST_GS_PIN:   src = lnk.gate_pin;
			GST_GS_T0OVF: src = t0_pulse_q;
			GST_GS_COMP:  src = lnk.comp_sync ? comp_s_q : lnk.comp_out;
			default:      src = 1'b0;
		endcase
	end

	assign active = (src == lnk.gate_pol);

	// Toggle flop flips on each activating edge, so one gate period counts
	always_ff @(posedge clk) begin
		if (!nrst) begin
			active_prev_q <= 1'b0;
			tff_q         <= 1'b0;
		end else if (ce) begin
			active_prev_q <= active;
			if (!lnk.toggle_mode || !lnk.timer_on) begin
				tff_q <= 1'b0;
			end else if (active && !active_prev_q) begin
				tff_q <= !tff_q;
			end
		end
	end

	assign lnk.gate_open = lnk.toggle_mode ? tff_q : active;

	a_toggle_held: assert property (@(posedge clk) disable iff (!nrst) ce && !lnk.toggle_mode |=> !tff_q)
		else $error("toggle flop not held clear");
	a_off_clears_tff: assert property (@(posedge clk) disable iff (!nrst) ce && !lnk.timer_on |=> !tff_q)
		else $error("timer off did not clear toggle flop");
	a_rsvd_source: assert property (@(posedge clk) disable iff (!nrst)
		lnk.gate_sel == 2'b11 && !lnk.toggle_mode |-> lnk.gate_open == !lnk.gate_pol)
		else $error("reserved gate source not low");

endmodule : gst_gate

`default_nettype wire

// [hw/gst_timer.sv]
// The strobed register port and the address map were decided locally.
`default_nettype none

// How it works
// - Sixteen-bit up-counter in two bytes; a byte write loads that byte at once.
// - Off while timer_on is 0; gate_enable decides free or gated counting.
// - Source field picks instruction, system, pin or crystal, capacitive oscillator.
// - System clock source adds one per clock, four per instruction cycle.
// - External sources count rising edges, with or without the extra sync stage.
// - After enable or count write an external source needs a falling edge before its first count.
// - The selected clock is divided by 1, 2, 4 or 8 before the counter.
// - Prescale counter is hidden from software and cleared on any count write.
// - Crystal amplifier runs whenever osc_enable is set, also in sleep.
// - sync_disable counts external edges directly and keeps counting in sleep.
// - Changing sync mode may drop or add a single increment.
// - Byte reads always return a settled value; software handles rollover between reads.
// - With gating on, count only while the gate is active, else hold.
// - Gate is active when its source equals gate_polarity.
// - Gate source: 00 pin, 01 eight-bit timer overflow, 10 comparator, 11 reserved.
// - Eight-bit timer wrap from ff to 00 makes a pulse for the gate.
// - Comparator gate source is either sampled on timer ticks or passed straight.
// - Toggle mode routes the gate through a flop flipping on each active edge.
// - With toggle mode clear the toggle flop is held at zero.
// - Prescale codes: 11 divide 8, 10 divide 4, 01 divide 2, 00 divide 1.
// - Clearing timer_on stops the count and clears the toggle flop.
// - Wrap from ffff to 0000 sets overflow_flag; only software clears it.

// ----------------------------------------------------------------
// Gated sixteen-bit timer, top level
// ----------------------------------------------------------------
module gst_timer (
	input  wire logic                 clk,                    // System clock, 10 MHz
	input  wire logic                 nrst,                   // Synchronous reset, active low
	input  wire logic                 ce,                     // Clock enable, freezes all state when low
	input  wire logic [gst_pkg::ADDR_W-1:0] addr,             // Register address
	input  wire logic [gst_pkg::DATA_W-1:0] wdata,            // Write data
	input  wire logic                 we,                     // Write strobe
	input  wire logic                 re,                     // Read strobe
	output logic [gst_pkg::DATA_W-1:0] rdata_q,               // Read data, cycle after re
	input  wire logic                 ext_clock_pin,          // External count input
	input  wire logic                 crystal_in_pin,         // Crystal amplifier input
	output logic                      crystal_out_pin_q,      // Crystal amplifier output
	input  wire logic                 cap_osc_in,             // Capacitive-sensing oscillator
	input  wire logic                 gate_pin,               // Gate pin
	input  wire logic [7:0]           eight_bit_timer,        // Value of the eight-bit timer
	input  wire logic                 comparator_gate_output, // Comparator output
	input  wire logic                 sleep,                  // Processor asleep
	output logic                      overflow_flag_q,        // Sticky overflow flag
	output logic                      wake_q                  // Overflow while asleep
);
	import gst_pkg::*;

	// ----------------------------------------------------------------
	// Registers and decoded fields
	// ----------------------------------------------------------------
	logic [15:0]   cnt_q;
	logic [7:0]    tcr_q;
	logic [7:0]    gcr_q;
	logic          csync_q;
	logic [1:0]    phase_q;
	logic          armed_q;
	gst_clk_src_t  cs;
	logic          timer_on;
	logic          osc_enable;
	logic          sync_disable;
	logic          gate_enable;
	logic          wr_low;
	logic          wr_high;
	logic          cnt_wr;
	logic          wr_aux;
	logic          sel_cur;
	logic          sel_prev;
	logic          ext_rise;
	logic          ext_fall;
	logic          run_ok;
	logic          src_tick;
	logic          inc;
	logic          ovf_set;
	logic [1:0]    ext_idx;
	logic [2:0]    ext_in;
	logic [2:0]    s0_q;
	logic [2:0]    s1_q;
	logic [2:0]    s2_q;
	logic [7:0]    cnt_hi;

	gst_link_if lnk ();

	assign cs           = gst_clk_src_t'(tcr_q[TCR_CS_LSB +: 2]);
	assign timer_on     = tcr_q[TCR_ON_BIT];
	assign osc_enable   = tcr_q[TCR_OSC_BIT];
	assign sync_disable = tcr_q[TCR_SYNC_BIT];
	assign gate_enable  = gcr_q[GCR_GE_BIT];

	// Write decodes; the count bytes share one clear path
	assign wr_low  = we && (addr == OFS_COUNT_LOW);
	assign wr_high = we && (addr == OFS_COUNT_HIGH);
	assign cnt_wr  = wr_low || wr_high;
	assign wr_aux  = we && (addr == OFS_AUX);

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	// Reserved bits are masked so they always read zero
	always_ff @(posedge clk) begin
		if (!nrst) begin
			tcr_q   <= TCR_RESET;
			gcr_q   <= GCR_RESET;
			csync_q <= AUX_CSYNC_RESET;
		end else if (ce) begin
			if (we && addr == OFS_TIMER_CTL) begin
				tcr_q <= wdata & TCR_RW_MASK;
			end
			if (we && addr == OFS_GATE_CTL) begin
				gcr_q <= wdata & GCR_RW_MASK;
			end
			if (wr_aux) begin
				csync_q <= wdata[AUX_CSYNC_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// Clock sources
	// ----------------------------------------------------------------
	// Instruction clock phase, free running
	always_ff @(posedge clk) begin
		if (!nrst) begin
			phase_q <= 2'h0;
		end else if (ce) begin
			phase_q <= 2'(phase_q + 2'h1);
		end
	end

	// External sources: pin, crystal, capacitive oscillator
	assign ext_in = {cap_osc_in, crystal_in_pin, ext_clock_pin};

	// Each source gets a three-deep sample chain; sync mode looks one stage later
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_ext
			always_ff @(posedge clk) begin
				if (!nrst) begin
					s0_q[gi] <= 1'b0;
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
				end else if (ce) begin
					s0_q[gi] <= ext_in[gi];
					s1_q[gi] <= s0_q[gi];
					s2_q[gi] <= s1_q[gi];
				end
			end
		end
	endgenerate

	// Source index for the pin/crystal code and the oscillator code
	always_comb begin
		case (cs)
			GST_CS_PIN: ext_idx = osc_enable ? 2'd1 : 2'd0;
			GST_CS_CAP: ext_idx = 2'd2;
			default:    ext_idx = 2'd0;
		endcase
	end

	// Direct path is one stage earlier, so a mode change can slip one edge
	assign sel_cur  = sync_disable ? s0_q[ext_idx] : s1_q[ext_idx];
	assign sel_prev = sync_disable ? s1_q[ext_idx] : s2_q[ext_idx];
	assign ext_rise = sel_cur && !sel_prev;
	assign ext_fall = !sel_cur && sel_prev;

	// A falling edge must be seen after enable or a count write
	always_ff @(posedge clk) begin
		if (!nrst) begin
			armed_q <= 1'b0;
		end else if (ce) begin
			if (!timer_on || cnt_wr) begin
				armed_q <= 1'b0;
			end else if (ext_fall) begin
				armed_q <= 1'b1;
			end
		end
	end

	// In sleep only the direct external path keeps ticking
	assign run_ok = timer_on && (!sleep || (gst_is_ext(cs) && sync_disable));

	// Raw tick before the prescaler
	always_comb begin
		case (cs)
			GST_CS_SYS:   src_tick = 1'b1;
			GST_CS_INSTR: src_tick = (phase_q == INSTR_LAST);
			GST_CS_PIN:   src_tick = ext_rise && armed_q;
			GST_CS_CAP:   src_tick = ext_rise && armed_q;
			default:      src_tick = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Prescaler and gate
	// ----------------------------------------------------------------
	assign lnk.raw_tick    = src_tick && run_ok;
	assign lnk.cnt_clear   = cnt_wr;
	assign lnk.ps_sel      = tcr_q[TCR_PS_LSB +: 2];
	assign lnk.timer_on    = timer_on;
	assign lnk.toggle_mode = gcr_q[GCR_TM_BIT];
	assign lnk.gate_pol    = gcr_q[GCR_POL_BIT];
	assign lnk.gate_sel    = gcr_q[GCR_GSS_LSB +: 2];
	assign lnk.comp_sync   = csync_q;
	assign lnk.gate_pin    = gate_pin;
	assign lnk.t0_count    = eight_bit_timer;
	assign lnk.comp_out    = comparator_gate_output;

	gst_prescaler u_pre (
		.clk  (clk),
		.nrst (nrst),
		.ce   (ce),
		.lnk  (lnk.pre)
	);

	gst_gate u_gate (
		.clk  (clk),
		.nrst (nrst),
		.ce   (ce),
		.lnk  (lnk.gate)
	);

	// ----------------------------------------------------------------
	// Counter and overflow
	// ----------------------------------------------------------------
	assign inc     = lnk.pre_tick && (!gate_enable || lnk.gate_open);
	assign ovf_set = inc && (cnt_q == COUNT_MAX) && !cnt_wr;

	// A write wins over a coinciding increment; stopping first avoids the race
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cnt_q <= COUNT_RESET;
		end else if (ce) begin
			if (wr_low) begin
				cnt_q[7:0] <= wdata;
			end else if (wr_high) begin
				cnt_q[15:8] <= wdata;
			end else if (inc) begin
				cnt_q <= 16'(cnt_q + 16'h1);
			end
		end
	end

	// Sticky flag: set wins over a software clear in the same cycle
	always_ff @(posedge clk) begin
		if (!nrst) begin
			overflow_flag_q <= 1'b0;
			wake_q          <= 1'b0;
		end else if (ce) begin
			overflow_flag_q <= ovf_set || (overflow_flag_q && !(wr_aux && !wdata[AUX_OVF_BIT]));
			wake_q          <= ovf_set && sleep;
		end
	end

	// Crystal amplifier inverts its input while enabled, asleep or not
	always_ff @(posedge clk) begin
		if (!nrst) begin
			crystal_out_pin_q <= 1'b0;
		end else if (ce) begin
			crystal_out_pin_q <= osc_enable && !crystal_in_pin;
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	// High byte alias, so the read check can look back at it
	assign cnt_hi = cnt_q[15:8];

	// Bytes come from the settled counter flops, so each read is whole
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rdata_q <= 8'h00;
		end else if (ce) begin
			if (re) begin
				case (addr)
					OFS_COUNT_LOW:  rdata_q <= cnt_q[7:0];
					OFS_COUNT_HIGH: rdata_q <= cnt_q[15:8];
					OFS_TIMER_CTL:  rdata_q <= tcr_q;
					OFS_GATE_CTL:   rdata_q <= gcr_q;
					OFS_AUX:        rdata_q <= {6'h00, csync_q, overflow_flag_q};
					default:        rdata_q <= 8'h00;
				endcase
			end else begin
				rdata_q <= 8'h00;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_low_byte_load: assert property (@(posedge clk) disable iff (!nrst)
		ce && wr_low |=> cnt_q[7:0] == $past(wdata))
		else $error("low count byte not loaded");
	a_off_holds: assert property (@(posedge clk) disable iff (!nrst)
		!timer_on && !cnt_wr |=> cnt_q == $past(cnt_q))
		else $error("counter moved while off");
	a_sysclk_rate: assert property (@(posedge clk) disable iff (!nrst)
		ce && timer_on && cs == GST_CS_SYS && lnk.ps_sel == 2'b00 && !gate_enable && !sleep && !cnt_wr
		|=> cnt_q == 16'($past(cnt_q) + 16'h1))
		else $error("system clock source missed a count");
	a_needs_fall: assert property (@(posedge clk) disable iff (!nrst)
		gst_is_ext(cs) && !armed_q |-> !inc)
		else $error("external count before falling edge");
	a_gate_hold: assert property (@(posedge clk) disable iff (!nrst)
		gate_enable && !lnk.gate_open && !cnt_wr |=> cnt_q == $past(cnt_q))
		else $error("counter moved with gate closed");
	a_ovf_set: assert property (@(posedge clk) disable iff (!nrst)
		ce && inc && cnt_q == COUNT_MAX && !cnt_wr |=> overflow_flag_q && cnt_q == COUNT_RESET)
		else $error("rollover did not set the flag");
	a_sleep_freeze: assert property (@(posedge clk) disable iff (!nrst)
		sleep && !sync_disable && !cnt_wr |=> cnt_q == $past(cnt_q))
		else $error("synchronous count moved in sleep");
	a_high_byte_load: assert property (@(posedge clk) disable iff (!nrst)
		ce && wr_high |=> cnt_q[15:8] == $past(wdata))
		else $error("high count byte not loaded");
	a_instr_rate: assert property (@(posedge clk) disable iff (!nrst)
		ce && timer_on && cs == GST_CS_INSTR && phase_q != INSTR_LAST && !cnt_wr |=> cnt_q == $past(cnt_q))
		else $error("instruction clock counted off phase");
	a_xtal_runs: assert property (@(posedge clk) disable iff (!nrst)
		ce && osc_enable && !crystal_in_pin |=> crystal_out_pin_q)
		else $error("crystal amplifier not driving");
	a_xtal_idle: assert property (@(posedge clk) disable iff (!nrst)
		ce && !osc_enable |=> !crystal_out_pin_q)
		else $error("crystal amplifier on while disabled");
	a_wake_pulse: assert property (@(posedge clk) disable iff (!nrst)
		ce && ovf_set && sleep |=> wake_q)
		else $error("overflow in sleep gave no wake");
	a_read_high: assert property (@(posedge clk) disable iff (!nrst)
		ce && re && addr == OFS_COUNT_HIGH |=> rdata_q == $past(cnt_hi))
		else $error("high byte read not the counter");
	a_read_idle: assert property (@(posedge clk) disable iff (!nrst)
		ce && !re |=> rdata_q == 8'h00)
		else $error("read data stood past its cycle");
	a_ovf_sticky: assert property (@(posedge clk) disable iff (!nrst)
		ce && overflow_flag_q && !wr_aux |=> overflow_flag_q)
		else $error("overflow flag dropped on its own");

endmodule : gst_timer

`default_nettype wire

// [verif/test_gst_timer.sv]
`default_nettype none

// ----------------------------------------------------------------
// Self-checking bench: register bus tasks and directed sequences
// ----------------------------------------------------------------
module test_gst_timer;
	timeunit 1ns;
	timeprecision 1ns;
	import gst_pkg::*;

	logic       clk, nrst, we, re, gpin, comp, slp, woke;
	logic [2:0] xs;
	logic [7:0] t0;
	logic [2:0] addr;
	logic [7:0] wdata, rdata_q, v0, d;
	logic       ovf_q, wake_q, xout_q;
	int         n_errors, total_checks, cycles;
	// Gate cases: [5:4] source, [3] polarity, [2] pin, [1] comparator, [0] counts
	logic [5:0] gcase [10] = '{6'b001101, 6'b001000, 6'b000001, 6'b000100, 6'b101011,
		6'b101000, 6'b110001, 6'b111000, 6'b011000, 6'b010001};
	// External cases: control byte with the timer off, and the input that carries the pulses
	logic [7:0] xcfg [4] = '{8'h80, 8'h84, 8'hc0, 8'h88};
	int         xsel [4] = '{0, 0, 2, 1};

	gst_timer u_dut (.clk(clk), .nrst(nrst), .ce(1'b1), .addr(addr), .wdata(wdata), .we(we), .re(re),
		.rdata_q(rdata_q), .ext_clock_pin(xs[0]), .crystal_in_pin(xs[1]), .crystal_out_pin_q(xout_q),
		.cap_osc_in(xs[2]), .gate_pin(gpin), .eight_bit_timer(t0), .comparator_gate_output(comp),
		.sleep(slp), .overflow_flag_q(ovf_q), .wake_q(wake_q));

	// Clock, 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Hang guard: the sequence needs well under 5000 cycles
	// Eight-bit timer input wraps ff to 00 every 8 cycles; wake pulses are caught sticky
	always @(posedge clk) begin
		cycles <= cycles + 1;
		t0 <= {8{cycles[2]}};
		if (wake_q)
			woke <= 1'b1;
		if (cycles == 20000) begin
			n_errors++;
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk);
		we <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		we <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk);
		re <= 1'b1;
		addr <= a;
		@(posedge clk);
		re <= 1'b0;
		#1 v = rdata_q;
	endtask : rd

	// Low-byte advance over exactly 32 cycles between the two read strobes
	task automatic span(output logic [7:0] dv);
		logic [7:0] a0, a1;
		rd(OFS_COUNT_LOW, a0);
		repeat (30) @(posedge clk);
		rd(OFS_COUNT_LOW, a1);
		dv = a1 - a0;
	endtask : span

	task automatic pulses(input int n, input int idx);
		repeat (n) begin
			xs <= 3'(1 << idx);
			repeat (4) @(posedge clk);
			xs <= 3'h0;
			repeat (4) @(posedge clk);
		end
	endtask : pulses

	task automatic print_verdict;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		nrst = 1'b0; we = 1'b0; re = 1'b0; addr = 3'h0; wdata = 8'h00;
		xs = 3'h0; gpin = 1'b0; comp = 1'b0; slp = 1'b0; woke = 1'b0;
		n_errors = 0; total_checks = 0; cycles = 0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		// Everything idle after reset, unmapped places read zero
		for (int a = 0; a < 8; a++) begin
			rd(a[2:0], v0);
			check(v0, 8'h00);
		end
		// Byte writes land directly in the count
		wr(OFS_COUNT_LOW, 8'h34);
		wr(OFS_COUNT_HIGH, 8'h12);
		rd(OFS_COUNT_LOW, v0);
		check(v0, 8'h34);
		rd(OFS_COUNT_HIGH, v0);
		check(v0, 8'h12);
		// Instruction and system sources under every prescale code
		for (int s = 0; s < 2; s++) begin
			for (int p = 0; p < 4; p++) begin
				wr(OFS_TIMER_CTL, {1'b0, s[0], p[1:0], 4'b0001});
				span(d);
				check(d, 8'((s ? 32 : 8) >> p));
			end
		end
		// Wrap past ffff sets the sticky flag; a stopped timer holds
		wr(OFS_TIMER_CTL, 8'h00);
		wr(OFS_COUNT_LOW, 8'hfc);
		wr(OFS_COUNT_HIGH, 8'hff);
		check({7'h00, ovf_q}, 8'h00);
		wr(OFS_TIMER_CTL, 8'h41);
		repeat (10) @(posedge clk);
		wr(OFS_TIMER_CTL, 8'h40);
		span(d);
		check(d, 8'h00);
		check({7'h00, ovf_q}, 8'h01);
		rd(OFS_AUX, v0);
		check(v0 & 8'h01, 8'h01);
		wr(OFS_AUX, 8'h00);
		#1 check({7'h00, ovf_q}, 8'h00);
		// Gate source, polarity and the reserved code, settle before measuring
		wr(OFS_TIMER_CTL, 8'h41);
		foreach (gcase[i]) begin
			gpin <= gcase[i][2];
			comp <= gcase[i][1];
			wr(OFS_GATE_CTL, {1'b1, gcase[i][3], 4'b0000, gcase[i][5:4]});
			repeat (4) @(posedge clk);
			span(d);
			// The wrap pulse is one cycle in eight, so it opens 4 of 32 cycles
			v0 = (gcase[i][5:4] == 2'b01) ? 8'd4 : 8'd0;
			check(d, gcase[i][0] ? 8'd32 - v0 : v0);
		end
		// Comparator copy sampled on timer ticks still opens the gate
		wr(OFS_AUX, 8'h02);
		rd(OFS_AUX, v0);
		check(v0, 8'h02);
		comp <= 1'b1;
		wr(OFS_GATE_CTL, 8'hc2);
		span(d);
		check(d, 8'd32);
		// Toggle mode: polarity first, then toggle, never both in one write
		gpin <= 1'b1;
		wr(OFS_GATE_CTL, 8'hc0);
		wr(OFS_GATE_CTL, 8'he0);
		span(d);
		check(d, 8'h00);
		gpin <= 1'b0;
		repeat (2) @(posedge clk);
		gpin <= 1'b1;
		repeat (4) @(posedge clk);
		span(d);
		check(d, 8'd32);
		wr(OFS_TIMER_CTL, 8'h40);
		wr(OFS_TIMER_CTL, 8'h41);
		span(d);
		check(d, 8'h00);
		// External inputs enabled while low: first pulse only arms, two more wrap fffe to 0000
		wr(OFS_GATE_CTL, 8'h00);
		for (int k = 0; k < 4; k++) begin
			wr(OFS_TIMER_CTL, xcfg[k]);
			wr(OFS_COUNT_LOW, 8'hfe);
			wr(OFS_COUNT_HIGH, 8'hff);
			if (k == 3) repeat (40) @(posedge clk);
			check({7'h00, xout_q}, {7'h00, k == 3});
			wr(OFS_TIMER_CTL, xcfg[k] | 8'h01);
			slp <= (k == 1);
			pulses(3, xsel[k]);
			repeat (6) @(posedge clk);
			slp <= 1'b0;
			rd(OFS_COUNT_LOW, v0);
			check(v0, 8'h00);
			check({7'h00, woke}, {7'h00, k > 0});
		end
		print_verdict();
	end
endmodule : test_gst_timer

`default_nettype wire
